/* rtl/iwr_pkg.sv */
// constants, register map and types for the i2c wait/release control block
// assumes a 32-bit apb slave port and 8-bit registers in the low byte lanes
package iwr_pkg;
  localparam int IWR_AW = 8;
  // register byte offsets
  localparam logic [IWR_AW-1:0] IWR_OFS_CTRL = 8'h00;
  localparam logic [IWR_AW-1:0] IWR_OFS_STAT = 8'h04;
  localparam logic [IWR_AW-1:0] IWR_OFS_FLAG = 8'h08;
  localparam logic [IWR_AW-1:0] IWR_OFS_SADR = 8'h0c;
  localparam logic [IWR_AW-1:0] IWR_OFS_ISTS = 8'h10;
  localparam logic [IWR_AW-1:0] IWR_OFS_IMSK = 8'h14;
  localparam logic [7:0] IWR_RST_BYTE = 8'h00;
  // channel_control fields
  localparam int CC_EN = 7;
  localparam int CC_EXIT = 6;
  localparam int CC_WCAN = 5;
  localparam int CC_SPIE = 4;
  localparam int CC_WTIM = 3;
  localparam int CC_ACKE = 2;
  localparam int CC_STT = 1;
  localparam int CC_SPT = 0;
  // bus_status_register fields
  localparam int ST_MST = 7;
  localparam int ST_EXC = 6;
  localparam int ST_COI = 5;
  localparam int ST_TRC = 4;
  localparam int ST_ACKD = 3;
  localparam int ST_STD = 2;
  localparam int ST_SPD = 1;
  localparam int ST_WAIT = 0;
  // flag register fields
  localparam int FL_STBY = 4;
  localparam int FL_STCF = 3;
  localparam int FL_BSY = 2;
  localparam int FL_CLD = 1;
  localparam int FL_DAD = 0;
  // interrupt status / mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_WAIT = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_WAKE = 2;
  // serial clock counting
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_EIGHT = 4'h8;
  localparam logic [CNT_W-1:0] CNT_NINE = 4'h9;
  localparam logic [3:0] EXT_PREFIX = 4'h0;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } iwr_phase_t;
endpackage

/* rtl/iwr_ctrl.sv */
// i2c channel wait, release and interrupt-point control with apb registers
// assumes open-drain pins resolved outside; serial clock made by the partner
// Overview of operation
// [R1] exit request abandons transfer, floats lines, clears flags
// [R2] after exit, standby until stop detected
// [R3] standby also ends on address match or extension
// [R4] exit request self-clears after execution, zero at reset
// [R5] writing one releases wait; clears itself after
// [R6] disable resets status, fail, busy, level flags
// [R7] requests ignored while unit disabled
// [R8] enable with scl high, sda low means start
// [R9] request bits always read back as zero
// [R10] stop interrupt gated by enable bit, reset clear
// [R11] select zero: interrupt and wait at eighth fall
// [R12] select one: interrupt and wait at ninth fall
// [R13] address transfer interrupts at ninth fall always; code raises wake, and wait for an extension-code slave, at eighth fall
// [R14] select takes effect after address transfer
// [R15] master waits at ninth fall during address
// [R16] addressed slave waits at ninth fall after ack
// [R17] extension-code slave waits at eighth fall
// [R18] wait holds clock line low until released
//
// Local design decisions: the address map and register access over APB.
module iwr_ctrl
  import iwr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IWR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);

  function automatic logic [CNT_W-1:0] wait_point(input iwr_phase_t ph, input logic ext,
                                                  input logic mst, input logic wtim);
    if (ph == PH_ADDR) begin
      wait_point = (ext && !mst) ? CNT_EIGHT : CNT_NINE;
    end else begin
      wait_point = wtim ? CNT_NINE : CNT_EIGHT;
    end
  endfunction

  // pin synchronisers; stage 3 only gives the previous level for edges
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else if (ce) begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // control and status state
  logic en_q, en_d, en_prev_q, exit_q, exit_d, wcan_q, wcan_d;
  logic spie_q, spie_d, wtim_q, wtim_d, acke_q, acke_d, stt_q, stt_d, spt_q, spt_d;
  logic mst_q, mst_d, exc_q, exc_d, coi_q, coi_d, trc_q, trc_d;
  logic ackd_q, ackd_d, std_q, std_d, spd_q, spd_d, wait_q, wait_d;
  logic stby_q, stby_d, stcf_q, stcf_d, bsy_q, bsy_d, cld_q, cld_d, dad_q, dad_d;
  logic ackdrv_q, ackdrv_d, stdrv_q, stdrv_d;
  logic rose_q, rose_d, sda_oe_q;
  logic [7:0] sadr_q, sadr_d, shift_q, shift_d;
  logic [IRQ_W-1:0] ists_q, ists_d, imsk_q, imsk_d, ev;
  logic [CNT_W-1:0] cnt_q, cnt_d, cnt_n;
  iwr_phase_t ph_q, ph_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d, irq_q;
  logic scl_rise, scl_fall, start_det, stop_det, wr, match, ext;

  assign wr = psel && penable && pwrite && pready_q;
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  // enabling with scl high and sda low reads as a start at once
  assign start_det = en_q && scl_s2_q && ((scl_s3_q && !sda_s2_q && sda_s3_q) ||
                     (!en_prev_q && !sda_s2_q)); // R8
  assign stop_det = en_q && scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;
  assign match = (shift_q[7:1] == sadr_q[6:0]);
  assign ext = (shift_q[7:4] == EXT_PREFIX);

  always_comb begin
    en_d = en_q;
    exit_d = exit_q;
    wcan_d = wcan_q;
    spie_d = spie_q;
    wtim_d = wtim_q;
    acke_d = acke_q;
    stt_d = stt_q;
    spt_d = spt_q;
    mst_d = mst_q;
    exc_d = exc_q;
    coi_d = coi_q;
    trc_d = trc_q;
    ackd_d = ackd_q;
    std_d = std_q;
    spd_d = spd_q;
    wait_d = wait_q;
    stby_d = stby_q;
    stcf_d = stcf_q;
    bsy_d = bsy_q;
    cld_d = cld_q;
    dad_d = dad_q;
    ackdrv_d = ackdrv_q;
    stdrv_d = stdrv_q;
    sadr_d = sadr_q;
    shift_d = shift_q;
    imsk_d = imsk_q;
    cnt_d = cnt_q;
    // the fall right after a start closes no bit, so count only after a rise
    cnt_n = rose_q ? cnt_q + CNT_ONE : cnt_q;
    rose_d = rose_q;
    ph_d = ph_q;
    ev = '0;
    ists_d = ists_q;
    if (wr) begin
      case (paddr)
        IWR_OFS_CTRL: begin
          en_d = pwdata[CC_EN];
          spie_d = pwdata[CC_SPIE];
          wtim_d = pwdata[CC_WTIM];
          acke_d = pwdata[CC_ACKE];
          stt_d = pwdata[CC_STT] | stt_q;
          spt_d = pwdata[CC_SPT] | spt_q;
          // request bits only act on an enabled unit
          exit_d = pwdata[CC_EXIT] && pwdata[CC_EN]; // R7
          wcan_d = (pwdata[CC_WCAN] && pwdata[CC_EN]) || wcan_q; // R5 R7
        end
        IWR_OFS_SADR: sadr_d = pwdata[7:0];
        IWR_OFS_IMSK: imsk_d = pwdata[IRQ_W-1:0];
        IWR_OFS_ISTS: ists_d = ists_q & ~pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (en_q) begin
      cld_d = scl_s2_q;
      dad_d = sda_s2_q;
      if (start_det) begin
        bsy_d = 1'b1;
        std_d = 1'b1;
        spd_d = 1'b0;
        ph_d = PH_ADDR;
        cnt_d = CNT_ZERO;
        {exc_d, coi_d, trc_d, ackd_d} = 4'h0;
        rose_d = 1'b0;
        stt_d = 1'b0;
      end
      if (stop_det) begin
        bsy_d = 1'b0;
        spd_d = 1'b1;
        std_d = 1'b0;
        ph_d = PH_IDLE;
        mst_d = 1'b0;
        spt_d = 1'b0;
        wait_d = 1'b0;
        ackdrv_d = 1'b0;
        stby_d = 1'b0; // R2
        rose_d = 1'b0;
        ev[IRQ_STOP] = spie_q; // R10
      end
      if (scl_rise && ph_q != PH_IDLE) begin
        rose_d = 1'b1;
        if (cnt_q < CNT_EIGHT) begin
          shift_d = {shift_q[6:0], sda_s2_q};
        end else if (!sda_s2_q && !ackdrv_q) begin
          ackd_d = 1'b1;
        end
      end
      if (scl_fall && ph_q != PH_IDLE) begin
        stdrv_d = 1'b0;
        rose_d = 1'b0;
        cnt_d = cnt_n;
        if (cnt_n == CNT_EIGHT && ph_q == PH_ADDR) begin
          coi_d = match;
          exc_d = ext;
          trc_d = mst_q ? !shift_q[0] : shift_q[0];
          if (match || ext) begin
            stby_d = 1'b0; // R3
            ev[IRQ_WAKE] = 1'b1;
          end
        end
        if (cnt_n == CNT_EIGHT) begin
          ackdrv_d = !stby_d && !mst_q && ((ph_q == PH_ADDR && match) ||
                     (ph_q == PH_DATA && acke_q && !trc_q && (coi_q || exc_q)));
        end
        // select is read per byte; the address byte uses fixed points
        if (!stby_d && (mst_q || coi_d || exc_d) &&
            cnt_n == wait_point(ph_q, exc_d, mst_q, wtim_q)) begin // R11 R12 R13 R14 R15 R16 R17
          wait_d = 1'b1;
          ev[IRQ_WAIT] = 1'b1;
        end
        if (cnt_n == CNT_NINE) begin
          ackdrv_d = 1'b0;
          cnt_d = CNT_ZERO;
          ph_d = PH_DATA;
        end
      end
      if (wcan_q && wait_q) begin
        wait_d = 1'b0; // R5
        wcan_d = 1'b0;
      end
      if (stt_q && !stdrv_q && !start_det) begin
        stt_d = 1'b0;
        if (bsy_q) begin
          stcf_d = 1'b1;
        end else begin
          stdrv_d = 1'b1;
          mst_d = 1'b1;
        end
      end
      if (exit_q) begin
        exit_d = 1'b0; // R4
        stby_d = 1'b1; // R1
        wait_d = 1'b0;
        ackdrv_d = 1'b0;
        stdrv_d = 1'b0;
        wcan_d = 1'b0;
        ph_d = PH_IDLE;
        {stt_d, spt_d, mst_d, exc_d, coi_d, trc_d, ackd_d, std_d} = 8'h00;
        rose_d = 1'b0;
      end
    end else begin
      // disabled unit: status, fail, busy and levels cleared, requests dropped
      {mst_d, exc_d, coi_d, trc_d, ackd_d, std_d, spd_d} = 7'h00; // R6
      {stcf_d, bsy_d, cld_d, dad_d} = 4'h0; // R6
      {exit_d, wcan_d, wait_d, stby_d, ackdrv_d, stdrv_d, stt_d, spt_d} = 8'h00; // R7
      ph_d = PH_IDLE;
      cnt_d = CNT_ZERO;
      rose_d = 1'b0;
    end
    ists_d = ists_d | ev;
  end

  // apb read path: data and error latched in setup, held through access
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && !penable) begin
      pslverr_d = 1'b0;
      prdata_d = '0;
      case (paddr)
        IWR_OFS_CTRL: prdata_d[7:0] = {en_q, 2'b00, spie_q, wtim_q, acke_q, stt_q, spt_q}; // R9
        IWR_OFS_STAT: prdata_d[7:0] = {mst_q, exc_q, coi_q, trc_q, ackd_q, std_q, spd_q, wait_q};
        IWR_OFS_FLAG: prdata_d[7:0] = {3'b000, stby_q, stcf_q, bsy_q, cld_q, dad_q};
        IWR_OFS_SADR: prdata_d[7:0] = sadr_q;
        IWR_OFS_ISTS: prdata_d[IRQ_W-1:0] = ists_q;
        IWR_OFS_IMSK: prdata_d[IRQ_W-1:0] = imsk_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {en_q, en_prev_q, exit_q, wcan_q, spie_q, wtim_q, acke_q, stt_q, spt_q} <= 9'h000;
      {mst_q, exc_q, coi_q, trc_q, ackd_q, std_q, spd_q, wait_q} <= IWR_RST_BYTE;
      {stby_q, stcf_q, bsy_q, cld_q, dad_q, ackdrv_q, stdrv_q} <= 7'h00;
      {rose_q, sda_oe_q} <= 2'b00;
      sadr_q <= IWR_RST_BYTE;
      shift_q <= IWR_RST_BYTE;
      ists_q <= '0;
      imsk_q <= '0;
      cnt_q <= CNT_ZERO;
      ph_q <= PH_IDLE;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      en_q <= en_d;
      en_prev_q <= en_q;
      exit_q <= exit_d;
      wcan_q <= wcan_d;
      spie_q <= spie_d;
      wtim_q <= wtim_d;
      acke_q <= acke_d;
      stt_q <= stt_d;
      spt_q <= spt_d;
      mst_q <= mst_d;
      exc_q <= exc_d;
      coi_q <= coi_d;
      trc_q <= trc_d;
      ackd_q <= ackd_d;
      std_q <= std_d;
      spd_q <= spd_d;
      wait_q <= wait_d;
      stby_q <= stby_d;
      stcf_q <= stcf_d;
      bsy_q <= bsy_d;
      cld_q <= cld_d;
      dad_q <= dad_d;
      ackdrv_q <= ackdrv_d;
      stdrv_q <= stdrv_d;
      rose_q <= rose_d;
      sda_oe_q <= ackdrv_d || stdrv_d;
      sadr_q <= sadr_d;
      shift_q <= shift_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= 1'b1;
      irq_q <= |(ists_d & imsk_d);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // open drain: the driven level is always low, only the enables move
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = wait_q; // R18
  assign sda_oe = sda_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fall_data(logic [CNT_W-1:0] n);
    ce && en_q && scl_fall && ph_q == PH_DATA && cnt_n == n && !stby_q && !wait_q;
  endsequence
  sequence s_fall_addr9;
    ce && en_q && scl_fall && ph_q == PH_ADDR && cnt_n == CNT_NINE && !stby_q && !exc_q;
  endsequence

  AST_REQ_READ_ZERO: assert property ( // R9
    (psel && penable && pready && !pwrite && paddr == IWR_OFS_CTRL) |-> prdata[6:5] == 2'b00)
    else $error("request bits read back nonzero");
  AST_EXIT_SELF_CLEAR: assert property ((ce && exit_q) |=> !exit_q) // R4
    else $error("exit request did not self clear");
  AST_EXIT_FLOATS: assert property ((ce && en_q && exit_q) |=> // R1
    (stby_q && !mst_q && !coi_q && !std_q && !scl_oe && !sda_oe))
    else $error("exit left lines driven or flags set");
  AST_STBY_UNTIL_STOP: assert property ((ce && en_q && stby_q && !stop_det && !scl_fall) |=> stby_q) // R2
    else $error("standby left without stop or address");
  AST_WAIT_RELEASE: assert property ((ce && en_q && wait_q && wcan_q) |=> !wait_q && !scl_oe) // R5
    else $error("wait not released by cancel request");
  AST_DISABLED_CLEAR: assert property ((ce && !en_q) |=> // R6 R7
    (!bsy_q && !stcf_q && !cld_q && !wait_q && !std_q))
    else $error("disabled unit kept status");
  AST_STOP_IRQ_GATE: assert property ((ce && stop_det && !spie_q && !ists_q[IRQ_STOP] && // R10
    !(wr && paddr == IWR_OFS_ISTS)) |=> !ists_q[IRQ_STOP])
    else $error("stop interrupt raised while disabled");
  AST_WAIT_EIGHTH: assert property ((s_fall_data(CNT_EIGHT) and (!wtim_q && // R11
    (mst_q || coi_q || exc_q) && !exit_q)) |=> wait_q ##0 scl_oe ##0 ists_q[IRQ_WAIT])
    else $error("no wait at eighth fall");
  AST_WAIT_NINTH: assert property ((s_fall_data(CNT_EIGHT) and (wtim_q && !exit_q)) |=> // R12
    !wait_q)
    else $error("wait at eighth fall with ninth selected");
  AST_WAIT_NINTH_SET: assert property ((s_fall_data(CNT_NINE) and (wtim_q && // R12
    (mst_q || coi_q || exc_q) && !exit_q)) |=> wait_q ##0 scl_oe ##0 ists_q[IRQ_WAIT])
    else $error("no wait at ninth fall with ninth selected");
  AST_ADDR_NINTH: assert property ((s_fall_addr9 and ((mst_q || coi_q) && !exit_q)) |=> // R13 R15 R16
    (wait_q && ists_q[IRQ_WAIT] && ph_q == PH_DATA))
    else $error("no wait or interrupt at ninth fall of address");
endmodule

/* tb/iwr_bus_master.sv */
// i2c master model driving the serial pins at an 80 ns bit period
// assumes open-drain lines with pull-ups, resolved by the bench
module iwr_bus_master (
  // resolved line levels
  input wire logic scl_bus,
  input wire logic sda_bus,
  // pull-low drives
  output logic scl_low,
  output logic sda_low,
  // acknowledge seen in the latest clock
  output logic ack_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    ack_low = 1'b0;
  end
  task automatic set_sda(input logic low);
    sda_low = low;
  endtask
  // a slave may stretch the clock, so wait for the line itself
  task automatic bit_c(input logic b);
    sda_low = !b;
    #20 scl_low = 1'b0;
    wait (scl_bus === 1'b1);
    #20 ack_low = !sda_bus;
    #20 scl_low = 1'b1;
    #20;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n);
    sda_low = 1'b1;
    #20 scl_low = 1'b1;
    for (int j = 0; j <= n; j++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_c(j == 0 ? a[i] : d[i]);
      end
      bit_c(1'b1);
    end
    sda_low = 1'b1;
    #20 scl_low = 1'b0;
    wait (scl_bus === 1'b1);
    #20 sda_low = 1'b0;
    #40;
  endtask
endmodule

/* tb/iwr_ctrl_bench.sv */
// self-checking bench for the wait and release control block
// assumes zero-wait apb answers and an i2c master model on the pins
module iwr_ctrl_bench
  import iwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] EN = 8'h01 << CC_EN;
  localparam logic [7:0] EXIT = 8'h01 << CC_EXIT;
  localparam logic [7:0] WCAN = 8'h01 << CC_WCAN;
  localparam logic [7:0] SPIE = 8'h01 << CC_SPIE;
  localparam logic [7:0] WTIM = 8'h01 << CC_WTIM;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic scl_out, scl_oe, sda_out, sda_oe, scl_m, sda_m, ack_low, oe_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire scl_bus = !(scl_oe && !scl_out || scl_m);
  wire sda_bus = !(sda_oe && !sda_out || sda_m);
  int num_errors = 0;
  int num_checks = 0;
  int rises = 0;
  int cyc = 0;
  iwr_ctrl iwr_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_bus), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  iwr_bus_master iwr_bus_master_inst (.scl_bus(scl_bus), .sda_bus(sda_bus),
    .scl_low(scl_m), .sda_low(sda_m), .ack_low(ack_low));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  always @(posedge scl_bus) rises++;
  // about fifteen hundred cycles are needed; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc++;
    if (scl_oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rg(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wpt();
    while (scl_oe !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rel(input logic [7:0] c);
    chk("scl_held", scl_bus, 1'b0);
    chk("irq_wait", irq, 1'b1);
    wr(IWR_OFS_ISTS, 8'h01);
    wr(IWR_OFS_CTRL, c | WCAN);
    repeat (2) @(posedge clk_sys);
    chk("scl_free", scl_oe, 1'b0);
    chk("irq_clear", irq, 1'b0);
    rg(IWR_OFS_CTRL);
    chk("ctrl_readback", rd, {24'h0, c});
  endtask
  task automatic exit_chk();
    rg(IWR_OFS_STAT);
    chk("exit_status", {rd[7:2], rd[0]}, 7'h00);
    rg(IWR_OFS_FLAG);
    chk("standby_on", rd[FL_STBY], 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rg(IWR_OFS_CTRL);
    chk("ctrl_reset", rd, 32'h0);
    rg(8'h18);
    chk("unmapped_err", pslverr, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    $display("test reset done");
    wr(IWR_OFS_SADR, 8'h2a);
    wr(IWR_OFS_IMSK, 8'h01);
    iwr_bus_master_inst.set_sda(1'b1);
    repeat (4) @(posedge clk_sys);
    wr(IWR_OFS_CTRL, EN | SPIE);
    rg(IWR_OFS_STAT);
    chk("start_on_enable", rd[ST_STD], 1'b1);
    wr(IWR_OFS_CTRL, EN | SPIE | EXIT);
    exit_chk();
    rg(IWR_OFS_CTRL);
    chk("exit_readback", rd, {24'h0, EN | SPIE});
    iwr_bus_master_inst.set_sda(1'b0);
    repeat (8) @(posedge clk_sys);
    rg(IWR_OFS_FLAG);
    chk("standby_off", rd[FL_STBY], 1'b0);
    $display("test enable and exit done");
    wr(IWR_OFS_ISTS, 8'h07);
    rises = 0;
    fork
      iwr_bus_master_inst.xfer(8'h54, 8'h11, 1);
      begin
        wpt();
        chk("addr_wait_point", rises, 9);
        chk("addr_ack", ack_low, 1'b1);
        rel(EN | SPIE);
        wpt();
        chk("data_wait_eighth", rises, 17);
        rel(EN | SPIE);
      end
    join
    repeat (8) @(posedge clk_sys);
    rg(IWR_OFS_ISTS);
    chk("stop_irq_on", rd[IRQ_STOP], 1'b1);
    $display("test wait at eighth done");
    wr(IWR_OFS_CTRL, EN);
    wr(IWR_OFS_ISTS, 8'h07);
    fork
      iwr_bus_master_inst.xfer(8'h54, 8'h00, 1);
      begin
        wpt();
        wr(IWR_OFS_CTRL, EN | EXIT);
        repeat (3) @(posedge clk_sys);
        chk("exit_float", {scl_oe, sda_oe}, 2'b00);
        oe_seen = 1'b0;
        exit_chk();
      end
    join
    chk("standby_no_wait", oe_seen, 1'b0);
    repeat (8) @(posedge clk_sys);
    rg(IWR_OFS_FLAG);
    chk("standby_off", rd[FL_STBY], 1'b0);
    rg(IWR_OFS_ISTS);
    chk("stop_irq_off", rd[IRQ_STOP], 1'b0);
    $display("test exit in transfer done");
    wr(IWR_OFS_CTRL, EN | EXIT);
    exit_chk();
    wr(IWR_OFS_ISTS, 8'h07);
    rises = 0;
    fork
      iwr_bus_master_inst.xfer({EXT_PREFIX, 4'h6}, 8'h00, 0);
      begin
        wpt();
        chk("ext_wait_eighth", rises, 8);
        rg(IWR_OFS_FLAG);
        chk("standby_wake", rd[FL_STBY], 1'b0);
        rg(IWR_OFS_ISTS);
        chk("wake_irq", rd[IRQ_WAKE], 1'b1);
        rel(EN);
      end
    join
    $display("test extension code done");
    wr(IWR_OFS_CTRL, EN | WTIM);
    rises = 0;
    fork
      iwr_bus_master_inst.xfer(8'h54, 8'h22, 1);
      begin
        wpt();
        chk("addr_wait_fixed", rises, 9);
        rel(EN | WTIM);
        wpt();
        chk("data_wait_ninth", rises, 18);
        rg(IWR_OFS_FLAG);
        chk("busy_before_off", rd[FL_BSY], 1'b1);
        wr(IWR_OFS_CTRL, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("off_release", scl_oe, 1'b0);
        rg(IWR_OFS_STAT);
        chk("off_status", rd, 32'h0);
        rg(IWR_OFS_FLAG);
        chk("off_flags", rd[3:0], 4'h0);
        wr(IWR_OFS_CTRL, EXIT | WCAN);
        rg(IWR_OFS_FLAG);
        chk("off_no_standby", rd[FL_STBY], 1'b0);
      end
    join
    $display("test disable at wait done");
    complete_run();
  end
endmodule
